// ### core/hdiv_top.v
// Memory-mapped 32-bit integer divider with a classic Wishbone slave
//
// Functional notes
// - Divide 32-bit dividend by 32-bit divisor, signed or unsigned per sign mode.
// - Full 32-bit quotient and remainder land in separate readable registers.
// - Nonzero division finishes eight clocks after the start trigger.
// - Writing the divisor register alone starts a division with current settings.
// - Zero divisor ends at once, zeroes both results, sets the zero flag.
// - Result reads during a division return the previous completed results.
// - End flag reads one once the division has finished.
// - Two status indications exist: divide-by-zero and end of division.
// - Sign mode zero means unsigned, one means signed; reset is unsigned.
// - Status bit 0 is end, bit 1 is zero; read-only, reset to zero.
// - Divisor register sits at 0x04 and resets to one.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "hdiv_consts.vh"

module hdiv_top (
	input  wire        CLK,
	input  wire        SYS_RST,
	input  wire        CLK_EN,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [4:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output wire [31:0] WB_DAT_O,
	output wire        WB_ACK_O,
	output wire        DIV_BUSY
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Byte-lane merge of write data into a register
	function [31:0] lane_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  sel;
		integer      i;
		begin
			lane_merge = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
				end
			end
		end
	endfunction

	// Magnitude of an operand, two's complement when signed
	function [31:0] op_mag;
		input [31:0] val;
		input        is_signed;
		begin
			if (is_signed && val[31]) begin
				op_mag = ~val + 32'h00000001;
			end else begin
				op_mag = val;
			end
		end
	endfunction

	// Conditional negate of a result magnitude
	function [31:0] neg_if;
		input [31:0] val;
		input        neg;
		begin
			if (neg) begin
				neg_if = ~val + 32'h00000001;
			end else begin
				neg_if = val;
			end
		end
	endfunction

	// Word address decode to a one-hot register select
	function [5:0] reg_decode;
		input [4:0] adr;
		begin
			case ({adr[4:2], 2'b00})
				`HDIV_OFS_DIVIDEND:  reg_decode = 6'h01;
				`HDIV_OFS_DIVISOR:   reg_decode = 6'h02;
				`HDIV_OFS_QUOTIENT:  reg_decode = 6'h04;
				`HDIV_OFS_REMAINDER: reg_decode = 6'h08;
				`HDIV_OFS_SIGN:      reg_decode = 6'h10;
				`HDIV_OFS_STATUS:    reg_decode = 6'h20;
				default:             reg_decode = 6'h00;
			endcase
		end
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam SEL_DEND = 0;
	localparam SEL_DSOR = 1;
	localparam SEL_QUOT = 2;
	localparam SEL_REMD = 3;
	localparam SEL_SIGN = 4;
	localparam SEL_STAT = 5;

	reg  [31:0] dividend_reg_ff;
	reg  [31:0] divisor_reg_ff;
	reg  [31:0] quotient_reg_ff;
	reg  [31:0] remainder_reg_ff;
	reg         sign_mode_ff;
	reg         end_flag_ff;
	reg         zero_flag_ff;
	reg         neg_quo_ff;
	reg         neg_rem_ff;
	reg         busy_ff;
	reg         ack_ff;
	reg  [31:0] dat_o_ff;
	reg  [31:0] nxt_dat_o;

	wire [5:0]  sel_hot;
	wire        bus_req;
	wire        wr_take;
	wire [31:0] nxt_divisor;
	wire        trigger;
	wire        trig_zero;
	wire        core_start;
	wire [31:0] dvd_mag;
	wire [31:0] dvs_mag;
	wire        core_last;
	wire [31:0] core_quo;
	wire [31:0] core_rem;

	// ****************************************************************
	// Wishbone slave handshake
	// ****************************************************************

	// Request pending and write acceptance at the acked edge
	assign sel_hot = reg_decode(WB_ADR_I);
	assign bus_req = WB_CYC_I & WB_STB_I;
	assign wr_take = bus_req & WB_WE_I & ack_ff;

	// One wait state, ack stands a single cycle
	always @(posedge CLK) begin
		if (SYS_RST) begin
			ack_ff <= 1'b0;
		end else if (CLK_EN) begin
			ack_ff <= bus_req & ~ack_ff;
		end
	end

	assign WB_ACK_O = ack_ff;

	// ****************************************************************
	// Operand and mode registers
	// ****************************************************************

	// Divisor value as it will stand after this write
	assign nxt_divisor = lane_merge(divisor_reg_ff, WB_DAT_I, WB_SEL_I);

	// Any divisor write launches an operation
	assign trigger    = wr_take & sel_hot[SEL_DSOR];
	assign trig_zero  = trigger & (nxt_divisor == 32'h00000000);
	assign core_start = trigger & ~trig_zero;

	// Dividend, divisor and sign mode writes
	always @(posedge CLK) begin
		if (SYS_RST) begin
			dividend_reg_ff <= `HDIV_RST_DIVIDEND;
			divisor_reg_ff  <= `HDIV_RST_DIVISOR;
			sign_mode_ff    <= `HDIV_RST_SIGN;
		end else if (CLK_EN && wr_take) begin
			if (sel_hot[SEL_DEND]) begin
				dividend_reg_ff <= lane_merge(dividend_reg_ff, WB_DAT_I, WB_SEL_I);
			end
			if (sel_hot[SEL_DSOR]) begin
				divisor_reg_ff <= nxt_divisor;
			end
			if (sel_hot[SEL_SIGN] && WB_SEL_I[0]) begin
				sign_mode_ff <= WB_DAT_I[`HDIV_SIGN_BIT];
			end
		end
	end

	// ****************************************************************
	// Division engine
	// ****************************************************************

	// Operate on magnitudes, fix signs at the end
	assign dvd_mag = op_mag(dividend_reg_ff, sign_mode_ff);
	assign dvs_mag = op_mag(nxt_divisor, sign_mode_ff);

	hdiv_step i_hdiv_step (
		.clk     (CLK),
		.rst     (SYS_RST),
		.ce      (CLK_EN),
		.start   (core_start),
		.dvd_mag (dvd_mag),
		.dvs_mag (dvs_mag),
		.last    (core_last),
		.res_quo (core_quo),
		.res_rem (core_rem)
	);

	// Result signs captured with the operands at the trigger
	always @(posedge CLK) begin
		if (SYS_RST) begin
			neg_quo_ff <= 1'b0;
			neg_rem_ff <= 1'b0;
		end else if (CLK_EN && core_start) begin
			neg_quo_ff <= sign_mode_ff & (dividend_reg_ff[31] ^ nxt_divisor[31]);
			neg_rem_ff <= sign_mode_ff & dividend_reg_ff[31];
		end
	end

	// ****************************************************************
	// Results and status flags
	// ****************************************************************

	// Results change only on completion; a run ended by a zero divisor is dropped
	always @(posedge CLK) begin
		if (SYS_RST) begin
			quotient_reg_ff  <= `HDIV_RST_QUOTIENT;
			remainder_reg_ff <= `HDIV_RST_REMAINDER;
			busy_ff          <= 1'b0;
		end else if (CLK_EN) begin
			if (trig_zero) begin
				quotient_reg_ff  <= 32'h00000000;
				remainder_reg_ff <= 32'h00000000;
				busy_ff          <= 1'b0;
			end else if (core_start) begin
				busy_ff <= 1'b1;
			end else if (core_last && busy_ff) begin
				quotient_reg_ff  <= neg_if(core_quo, neg_quo_ff);
				remainder_reg_ff <= neg_if(core_rem, neg_rem_ff);
				busy_ff          <= 1'b0;
			end
		end
	end

	// Nonzero trigger clears both flags, completion sets end; a zero divisor sets both at once
	always @(posedge CLK) begin
		if (SYS_RST) begin
			end_flag_ff  <= 1'b0;
			zero_flag_ff <= 1'b0;
		end else if (CLK_EN) begin
			if (trig_zero) begin
				end_flag_ff  <= 1'b1;
				zero_flag_ff <= 1'b1;
			end else if (core_start) begin
				end_flag_ff  <= 1'b0;
				zero_flag_ff <= 1'b0;
			end else if (core_last && busy_ff) begin
				end_flag_ff <= 1'b1;
			end
		end
	end

	assign DIV_BUSY = busy_ff;

	// ****************************************************************
	// Read path
	// ****************************************************************

	// Read mux; unmapped words and reserved bits read zero
	always @* begin
		nxt_dat_o = 32'h00000000;
		case (1'b1)
			sel_hot[SEL_DEND]: nxt_dat_o = dividend_reg_ff;
			sel_hot[SEL_DSOR]: nxt_dat_o = divisor_reg_ff;
			sel_hot[SEL_QUOT]: nxt_dat_o = quotient_reg_ff;
			sel_hot[SEL_REMD]: nxt_dat_o = remainder_reg_ff;
			sel_hot[SEL_SIGN]: nxt_dat_o[`HDIV_SIGN_BIT] = sign_mode_ff;
			sel_hot[SEL_STAT]: begin
				nxt_dat_o[`HDIV_STAT_END_BIT]  = end_flag_ff;
				nxt_dat_o[`HDIV_STAT_ZERO_BIT] = zero_flag_ff;
			end
			default: nxt_dat_o = 32'h00000000;
		endcase
	end

	// Read data registered with the ack
	always @(posedge CLK) begin
		if (SYS_RST) begin
			dat_o_ff <= 32'h00000000;
		end else if (CLK_EN && bus_req && !ack_ff) begin
			dat_o_ff <= nxt_dat_o;
		end
	end

	assign WB_DAT_O = dat_o_ff;

endmodule // hdiv_top
`default_nettype wire

// ### shared/hdiv_consts.vh
// Constants of the memory-mapped hardware integer divider
`ifndef HDIV_CONSTS_VH
`define HDIV_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define HDIV_OFS_DIVIDEND   5'h00
`define HDIV_OFS_DIVISOR    5'h04
`define HDIV_OFS_QUOTIENT   5'h08
`define HDIV_OFS_REMAINDER  5'h0C
`define HDIV_OFS_SIGN       5'h10
`define HDIV_OFS_STATUS     5'h14

// ****************************************************************
// Reset values
// ****************************************************************
`define HDIV_RST_DIVIDEND   32'h00000000
`define HDIV_RST_DIVISOR    32'h00000001
`define HDIV_RST_QUOTIENT   32'h00000000
`define HDIV_RST_REMAINDER  32'h00000000
`define HDIV_RST_SIGN       1'h0

// ****************************************************************
// Field positions
// ****************************************************************
`define HDIV_SIGN_BIT       0
`define HDIV_STAT_END_BIT   0
`define HDIV_STAT_ZERO_BIT  1

// ****************************************************************
// Timing
// ****************************************************************
`define HDIV_LATENCY        8
`define HDIV_BITS_PER_STEP  4
`define HDIV_LAST_STEP      3'h7

`endif

// ### core/hdiv_step.v
// Iterative unsigned divider core, four quotient bits per clock
`timescale 1ns/1ps
`default_nettype none
`include "hdiv_consts.vh"

module hdiv_step (
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	input  wire        start,
	input  wire [31:0] dvd_mag,
	input  wire [31:0] dvs_mag,
	output wire        last,
	output wire [31:0] res_quo,
	output wire [31:0] res_rem
);

	// ****************************************************************
	// State
	// ****************************************************************
	reg  [31:0] rem_ff;
	reg  [31:0] quo_ff;
	reg  [31:0] dvs_ff;
	reg  [2:0]  cnt_ff;
	reg         busy_ff;
	wire [31:0] r_w [0:`HDIV_BITS_PER_STEP];
	wire [31:0] q_w [0:`HDIV_BITS_PER_STEP];

	assign r_w[0] = rem_ff;
	assign q_w[0] = quo_ff;

	// ****************************************************************
	// Restoring stages, one quotient bit each
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < `HDIV_BITS_PER_STEP; g = g + 1) begin : g_stage
			wire [32:0] shifted;
			wire [33:0] diff;
			assign shifted = {r_w[g], q_w[g][31]};
			assign diff    = {1'b0, shifted} - {2'b00, dvs_ff};
			// Borrow means keep the shifted remainder
			assign r_w[g+1] = diff[33] ? shifted[31:0] : diff[31:0];
			assign q_w[g+1] = {q_w[g][30:0], ~diff[33]};
		end
	endgenerate

	// Final step this cycle: results are on the stage outputs
	assign last    = busy_ff & (cnt_ff == `HDIV_LAST_STEP);
	assign res_quo = q_w[`HDIV_BITS_PER_STEP];
	assign res_rem = r_w[`HDIV_BITS_PER_STEP];

	// Load on start, then eight steps of four bits
	always @(posedge clk) begin
		if (rst) begin
			rem_ff  <= 32'h00000000;
			quo_ff  <= 32'h00000000;
			dvs_ff  <= 32'h00000001;
			cnt_ff  <= 3'h0;
			busy_ff <= 1'b0;
		end else if (ce) begin
			if (start) begin
				rem_ff  <= 32'h00000000;
				quo_ff  <= dvd_mag;
				dvs_ff  <= dvs_mag;
				cnt_ff  <= 3'h0;
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				rem_ff  <= res_rem;
				quo_ff  <= res_quo;
				cnt_ff  <= cnt_ff + 3'h1;
				busy_ff <= ~last;
			end
		end
	end

endmodule // hdiv_step
`default_nettype wire

// ### testbench/hdiv_top_props.sv
// Assertion checker for the hardware integer divider
`timescale 1ns/1ps
`default_nettype none
module hdiv_top_props (
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic        CLK_EN,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [4:0]  WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        DIV_BUSY
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// ****************************************************************
	// Decoded bus events
	// ****************************************************************
	wire logic req    = WB_CYC_I && WB_STB_I && CLK_EN;
	wire logic dvs_wr = req && WB_WE_I && WB_ACK_O && (WB_ADR_I[4:2] == 3'h1) && (WB_SEL_I == 4'hF);
	wire logic rd_ack = WB_ACK_O && !WB_WE_I;
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
	a_ack_answer: assert property (req && !WB_ACK_O |=> WB_ACK_O) else $error("request not acked");
	a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(req)) else $error("ack without request");
	a_busy_start: assert property (dvs_wr && WB_DAT_I != 32'h0 |=> DIV_BUSY) else $error("division not started");
	a_busy_eight: assert property ((dvs_wr && WB_DAT_I != 32'h0) ##1 (!dvs_wr)[*8] |-> DIV_BUSY ##1 !DIV_BUSY)
		else $error("division length wrong");
	a_zero_idle: assert property (dvs_wr && WB_DAT_I == 32'h0 |=> !DIV_BUSY) else $error("zero divisor ran");
	a_busy_cause: assert property (!DIV_BUSY && !dvs_wr |=> !DIV_BUSY) else $error("busy without trigger");
	a_end_in_prog: assert property (rd_ack && WB_ADR_I[4:2] == 3'h5 && $past(DIV_BUSY) |-> !WB_DAT_O[0])
		else $error("end flag set while busy");
	a_stat_resv: assert property (rd_ack && WB_ADR_I[4:2] == 3'h5 |-> WB_DAT_O[31:2] == 30'h0)
		else $error("status reserved bits set");
	a_sign_resv: assert property (rd_ack && WB_ADR_I[4:2] == 3'h4 |-> WB_DAT_O[31:1] == 31'h0)
		else $error("sign reserved bits set");
	c_div_run: cover property (dvs_wr && WB_DAT_I != 32'h0);
	c_div_zero: cover property (dvs_wr && WB_DAT_I == 32'h0);
	c_busy_read: cover property (rd_ack && DIV_BUSY);
endmodule // hdiv_top_props
bind hdiv_top hdiv_top_props i_hdiv_top_props (.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .DIV_BUSY(DIV_BUSY));
`default_nettype wire

// ### testbench/hdiv_top_bench.sv
// Self-checking testbench of the hardware integer divider
`timescale 1ns/1ps
`default_nettype none
module hdiv_top_bench;
	logic        CLK, SYS_RST, CLK_EN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, DIV_BUSY;
	logic [4:0]  WB_ADR_I;
	logic [3:0]  WB_SEL_I;
	logic [31:0] WB_DAT_I, WB_DAT_O;
	int          failures = 0;
	int          comparisons = 0;
	int          cycles = 0;
	hdiv_top i_hdiv_top (.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
		.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
		.WB_ACK_O(WB_ACK_O), .DIV_BUSY(DIV_BUSY));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// One classic cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat, output logic [31:0] rd);
		@(posedge CLK);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= we;
		WB_ADR_I <= adr;
		WB_DAT_I <= dat;
		do @(posedge CLK); while (WB_ACK_O !== 1'b1);
		rd = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
	endtask
	// Full division with the documented software sequence
	task automatic do_div(input logic [31:0] sgn, dvd, dvs, q, r, st);
		logic [31:0] rd, prev;
		wb(1'b0, 5'h08, 32'h0, prev);
		wb(1'b1, 5'h10, sgn, rd);
		wb(1'b1, 5'h00, dvd, rd);
		wb(1'b1, 5'h04, dvs, rd);
		if (dvs != 32'h0) begin
			wb(1'b0, 5'h08, 32'h0, rd);
			chk("quotient in progress", prev, rd);
		end
		rd = 32'h0;
		for (int i = 0; i < 12 && rd[0] !== 1'b1; i++)
			wb(1'b0, 5'h14, 32'h0, rd);
		chk("status", st, rd);
		wb(1'b0, 5'h08, 32'h0, rd);
		chk("quotient", q, rd);
		wb(1'b0, 5'h0C, 32'h0, rd);
		chk("remainder", r, rd);
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		logic [31:0] rd;
		logic [31:0] exp [8] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, 5'(i * 4), 32'h0, rd);
			chk("reset value", exp[i], rd);
		end
		$display("reset test done");
	endtask
	task automatic t_unsigned;
		do_div(32'h0, 32'h7250A3FB, 32'h0000257D, 32'h00030CA2, 32'h00000EE1, 32'h1);
		do_div(32'h0, 32'hFFFFFFFF, 32'h00000010, 32'h0FFFFFFF, 32'h0000000F, 32'h1);
		$display("unsigned test done");
	endtask
	task automatic t_signed;
		do_div(32'h1, 32'hFFFFFFF9, 32'h00000002, 32'hFFFFFFFD, 32'hFFFFFFFF, 32'h1);
		do_div(32'h1, 32'h00000007, 32'hFFFFFFFE, 32'hFFFFFFFD, 32'h00000001, 32'h1);
		do_div(32'h1, 32'hFFFFFFF9, 32'hFFFFFFFE, 32'h00000003, 32'hFFFFFFFF, 32'h1);
		do_div(32'h1, 32'h80000000, 32'hFFFFFFFF, 32'h80000000, 32'h00000000, 32'h1);
		$display("signed test done");
	endtask
	task automatic t_zero;
		logic [31:0] rd;
		do_div(32'h0, 32'h00001234, 32'h00000000, 32'h0, 32'h0, 32'h3);
		wb(1'b1, 5'h00, 32'h00000009, rd);
		wb(1'b1, 5'h04, 32'h00000005, rd);
		wb(1'b1, 5'h04, 32'h00000000, rd);
		repeat (10) @(posedge CLK);
		wb(1'b0, 5'h08, 32'h0, rd);
		chk("quotient after zero restart", 32'h0, rd);
		wb(1'b0, 5'h0C, 32'h0, rd);
		chk("remainder after zero restart", 32'h0, rd);
		wb(1'b0, 5'h14, 32'h0, rd);
		chk("status after zero restart", 32'h3, rd);
		do_div(32'h0, 32'h00000009, 32'h00000003, 32'h3, 32'h0, 32'h1);
		$display("zero divisor test done");
	endtask
	task automatic t_midreset;
		logic [31:0] rd;
		wb(1'b1, 5'h00, 32'h00000064, rd);
		wb(1'b1, 5'h04, 32'h00000007, rd);
		SYS_RST <= 1'b1;
		repeat (2) @(posedge CLK);
		SYS_RST <= 1'b0;
		chk("busy after reset", 32'h0, {31'h0, DIV_BUSY});
		wb(1'b0, 5'h00, 32'h0, rd);
		chk("dividend after reset", 32'h0, rd);
		wb(1'b0, 5'h04, 32'h0, rd);
		chk("divisor after reset", 32'h1, rd);
		wb(1'b0, 5'h08, 32'h0, rd);
		chk("quotient after reset", 32'h0, rd);
		wb(1'b0, 5'h14, 32'h0, rd);
		chk("status after reset", 32'h0, rd);
		$display("mid-run reset test done");
	endtask
	task automatic t_freeze;
		logic [31:0] rd;
		@(posedge CLK);
		CLK_EN <= 1'b0;
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= 1'b1;
		WB_ADR_I <= 5'h00;
		WB_SEL_I <= 4'h3;
		WB_DAT_I <= 32'hFFFFA5A5;
		repeat (4) @(posedge CLK);
		chk("ack while frozen", 32'h0, {31'h0, WB_ACK_O});
		CLK_EN <= 1'b1;
		do @(posedge CLK); while (WB_ACK_O !== 1'b1);
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		WB_SEL_I <= 4'hF;
		wb(1'b0, 5'h00, 32'h0, rd);
		chk("dividend lane write", 32'h0000A5A5, rd);
		$display("freeze and lane test done");
	endtask
	task automatic t_access;
		logic [31:0] rd;
		wb(1'b1, 5'h08, 32'hFFFFFFFF, rd);
		wb(1'b1, 5'h14, 32'hFFFFFFFF, rd);
		wb(1'b1, 5'h18, 32'hFFFFFFFF, rd);
		wb(1'b1, 5'h10, 32'hFFFFFFFF, rd);
		wb(1'b0, 5'h08, 32'h0, rd);
		chk("quotient read-only", 32'h3, rd);
		wb(1'b0, 5'h14, 32'h0, rd);
		chk("status read-only", 32'h1, rd);
		wb(1'b0, 5'h18, 32'h0, rd);
		chk("unmapped word", 32'h0, rd);
		wb(1'b0, 5'h10, 32'h0, rd);
		chk("sign field", 32'h1, rd);
		$display("access test done");
	endtask
	// ****************************************************************
	// Clock, timeout and main sequence
	// ****************************************************************
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		{SYS_RST, CLK_EN, WB_CYC_I, WB_STB_I, WB_WE_I} = 5'h18;
		WB_ADR_I = 5'h00;
		WB_SEL_I = 4'hF;
		WB_DAT_I = 32'h0;
		repeat (12) @(posedge CLK);
		SYS_RST <= 1'b0;
		t_reset();
		t_unsigned();
		t_signed();
		t_zero();
		t_access();
		t_midreset();
		t_freeze();
		end_sim();
	end
endmodule // hdiv_top_bench
`default_nettype wire
